//--- dv/oscfc_host.sv
// Host side model: turns serial register accesses into byte strobes.
// Assumes the bank takes a strobe on the rising edge.
`timescale 1ns/10ps
`default_nettype none
module oscfc_host
(
    // Clock
    input wire logic i_ref_clk,
    // Access toward the bank
    output logic o_wr_stb,
    output logic o_rd_stb,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    // Read answer
    input wire logic [7:0] i_rdata,
    input wire logic i_rdata_vld
);
    initial
    begin
        o_wr_stb = 1'b0;
        o_rd_stb = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    // Idle lines show inverted values so stale data never looks right
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        o_addr = a;
        o_wdata = d;
        o_wr_stb = 1'b1;
        @(negedge i_ref_clk);
        o_wr_stb = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge i_ref_clk);
        o_addr = a;
        o_rd_stb = 1'b1;
        @(negedge i_ref_clk);
        o_rd_stb = 1'b0;
        o_addr = ~a;
        d = i_rdata;
        v = i_rdata_vld;
    endtask
endmodule
`default_nettype wire

//--- dv/oscfc_regs_assertions.sv
// Port checker for the oscillator register bank.
// Assumes one-cycle strobes and page 0 after any reset.
`timescale 1ns/10ps
`default_nettype none
module oscfc_regs_chk
(
    // Clock, reset and access
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    // Watched outputs
    input wire logic [7:0] o_rdata,
    input wire logic o_rdata_vld,
    input wire logic [10:0] o_hs_div,
    input wire logic [5:0] o_p2_ratio,
    input wire logic [42:0] o_fb_div,
    input wire logic signed [23:0] o_fine_offset,
    input wire logic o_fine_upd,
    input wire logic o_dev_reset,
    input wire logic o_cal_busy,
    input wire logic o_clk_out
);
    logic [1:0] page_r;
    logic ctl_w;
    assign ctl_w = i_wr_stb && page_r == 2'h0 && i_addr == oscfc_pkg::OFS_DEV_CTRL;
    // Shadow page, so writes on other pages are not taken as control writes
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            page_r <= 2'h0;
        else if (ctl_w && i_wdata[7])
            page_r <= 2'h0;
        else if (i_wr_stb && i_addr == oscfc_pkg::OFS_PAGE_SEL)
            page_r <= i_wdata[1:0];
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    sequence top_wr_s;
        i_wr_stb && page_r == 2'h0 && i_addr == oscfc_pkg::OFS_FINE_BYTE2;
    endsequence
    sequence busy_run_s;
        o_cal_busy [*8];
    endsequence
    dev_reset_a: assert property (ctl_w && i_wdata[7] |=> o_dev_reset)
        else $error("reset bit write gave no reset pulse");
    reset_clear_a: assert property (o_dev_reset |=> !o_dev_reset)
        else $error("reset pulse did not clear");
    cal_start_a: assert property ($rose(o_cal_busy) |-> $past(ctl_w && i_wdata[3], 2))
        else $error("calibration began without a start write");
    busy_run_a: assert property ($rose(o_cal_busy) |-> busy_run_s)
        else $error("calibration ended at once");
    div_hold_a: assert property (!$past(ctl_w && i_wdata[3]) && !o_dev_reset
        |-> $stable(o_hs_div) && $stable(o_fb_div) && $stable(o_p2_ratio))
        else $error("dividers moved without a start");
    fine_upd_a: assert property (top_wr_s |=> o_fine_upd
        && o_fine_offset[23:16] == $past(i_wdata))
        else $error("top offset byte did not apply");
    fine_hold_a: assert property (!o_fine_upd && !o_dev_reset |-> $stable(o_fine_offset))
        else $error("offset moved without update");
    p2_ratio_a: assert property (o_p2_ratio inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20})
        else $error("power of two ratio out of set");
    clk_half_a: assert property (o_clk_out |=> !o_clk_out)
        else $error("output clock high twice");
    clk_busy_a: assert property (o_cal_busy && $past(o_cal_busy, 2) |-> !o_clk_out)
        else $error("output clock ran during calibration");
endmodule
bind oscfc_regs oscfc_regs_chk i_chk (.i_ref_clk, .i_rst_b, .i_wr_stb, .i_rd_stb, .i_addr,
    .i_wdata, .o_rdata, .o_rdata_vld, .o_hs_div, .o_p2_ratio, .o_fb_div, .o_fine_offset,
    .o_fine_upd, .o_dev_reset, .o_cal_busy, .o_clk_out);
`default_nettype wire

//--- dv/oscillator_freq_control_regs_test.sv
// Self-checking bench of the oscillator register bank.
// Assumes the host model drives every access input.
`timescale 1ns/10ps
`default_nettype none
module oscillator_freq_control_regs_test;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr, rd, vld, upd, dr, busy, cko;
    logic [7:0] addr, wdata, rdata;
    logic [10:0] hs;
    logic [5:0] p2;
    logic [42:0] fb;
    logic signed [23:0] fo;
    int miscompares = 0;
    int n_compared = 0;
    always #2.5 clk = ~clk;
    oscfc_host h (.i_ref_clk(clk), .o_wr_stb(wr), .o_rd_stb(rd), .o_addr(addr),
        .o_wdata(wdata), .i_rdata(rdata), .i_rdata_vld(vld));
    oscfc_regs i_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_wr_stb(wr), .i_rd_stb(rd),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rdata_vld(vld), .o_hs_div(hs),
        .o_p2_ratio(p2), .o_fb_div(fb), .o_fine_offset(fo), .o_fine_upd(upd),
        .o_dev_reset(dr), .o_cal_busy(busy), .o_clk_out(cko));
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        h.rd(a, d, v);
        chk("read valid", v, 1);
        chk($sformatf("reg %h", a), d, e);
    endtask
    task automatic t_reset_vals();
        logic [7:0] ad[16] = '{8'h07, 8'h11, 8'h17, 8'h18, 8'h1a, 8'h1b, 8'h1c, 8'h1d,
            8'h1e, 8'h1f, 8'h45, 8'he7, 8'he8, 8'he9, 8'hff, 8'h08};
        logic [7:0] ex[16] = '{8'h00, 8'h01, 8'h54, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h64, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        chk("hs div", hs, 11'h054);
        chk("fb div", fb, 43'h06400000000);
        for (int i = 0; i < 16; i++)
            rc(ad[i], ex[i]);
    endtask
    task automatic t_reserved();
        logic [7:0] ad[6] = '{8'h07, 8'h11, 8'h18, 8'h1f, 8'h45, 8'hff};
        logic [7:0] wd[6] = '{8'h77, 8'hfe, 8'hff, 8'hff, 8'h7e, 8'hfc};
        logic [7:0] ex[6] = '{8'h00, 8'h00, 8'h77, 8'h07, 8'h01, 8'h00};
        for (int i = 0; i < 6; i++)
        begin
            h.wr(ad[i], wd[i]);
            rc(ad[i], ex[i]);
        end
        chk("no reset", dr, 0);
        h.wr(8'h11, 8'h01);
        h.wr(8'h18, 8'h00);
        h.wr(8'h1f, 8'h00);
    endtask
    task automatic t_dividers();
        logic [47:0] fbv = 48'h00c7519cf2bf;
        h.wr(8'h45, 8'h80);
        h.wr(8'h17, 8'h46);
        for (int i = 0; i < 6; i++)
            h.wr(8'(8'h1a + i), fbv[8*i+:8]);
        chk("hs held", hs, 11'h054);
        chk("fb held", fb, 43'h06400000000);
        for (int c = 0; c < 8; c++)
        begin
            h.wr(8'h18, {1'b0, 3'(c), 4'h7});
            h.wr(8'h07, 8'h08);
            chk("p2 ratio", p2, (c > 4) ? 32 : (1 << c));
            chk("hs div", hs, 11'h746);
            chk("fb div", fb, fbv[42:0]);
            @(negedge clk);
            chk("bypass busy", busy, 0);
        end
    endtask
    task automatic t_fine();
        logic [23:0] fv[3] = '{24'h7c88e8, 24'(-8161513), 24'h000000};
        logic [23:0] prev;
        for (int i = 0; i < 3; i++)
        begin
            prev = fo;
            h.wr(8'he7, fv[i][7:0]);
            h.wr(8'he8, fv[i][15:8]);
            chk("staged upd", upd, 0);
            // Part-select drops the sign so a negative word is not widened with ones
            chk("staged hold", fo[23:0], prev);
            rc(8'he8, fv[i][15:8]);
            h.wr(8'he9, fv[i][23:16]);
            chk("fine upd", upd, 1);
            chk("fine offset", fo[23:0], fv[i]);
        end
    endtask
    task automatic t_page();
        h.wr(8'hff, 8'h01);
        rc(8'h17, 8'h00);
        h.wr(8'h17, 8'h99);
        rc(8'hff, 8'h01);
        h.wr(8'hff, 8'h03);
        rc(8'h18, 8'h00);
        rc(8'hff, 8'h03);
        h.wr(8'hff, 8'h00);
        rc(8'h17, 8'h46);
    endtask
    task automatic t_cal();
        int n = 0;
        h.wr(8'h45, 8'h00);
        h.wr(8'h11, 8'h00);
        h.wr(8'h07, 8'h08);
        @(negedge clk);
        chk("cal busy", busy, 1);
        rc(8'h07, 8'h08);
        while (busy === 1'b1 && n < 2100)
        begin
            @(negedge clk);
            n++;
        end
        // Three busy cycles pass before the loop, and its last step sees idle
        chk("cal length", n, oscfc_pkg::CAL_CYCLES - 2);
        rc(8'h07, 8'h00);
        h.wr(8'h11, 8'h01);
    endtask
    task automatic t_gate();
        int n = 0;
        h.wr(8'h11, 8'h00);
        repeat (3) @(negedge clk);
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk);
            chk("gated clk", cko, 0);
        end
        h.wr(8'h11, 8'h01);
        repeat (2) @(negedge clk);
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk);
            n += int'(cko === 1'b1);
        end
        chk("clk highs", n, 4);
        // Calibration with the gate open must still hold the clock low
        h.wr(8'h07, 8'h08);
        repeat (3) @(negedge clk);
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk);
            chk("busy gated clk", cko, 0);
        end
    endtask
    task automatic t_soft();
        h.wr(8'h07, 8'h88);
        chk("dev reset", dr, 1);
        chk("hs reset", hs, 11'h054);
        @(negedge clk);
        chk("reset clear", dr, 0);
        chk("no cal", busy, 0);
        rc(8'h17, 8'h54);
        rc(8'h07, 8'h00);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #400000;
        miscompares++;
        tally_and_finish();
    end
    initial
    begin
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        t_reset_vals();
        t_reserved();
        t_dividers();
        t_fine();
        t_page();
        t_cal();
        t_gate();
        t_soft();
        tally_and_finish();
    end
endmodule
`default_nettype wire

//--- verilog/oscfc_cal.sv
// Frequency calibration sequencer: busy for a fixed time after a start.
// Assumes start and clear are one-cycle pulses from the register bank.
`timescale 1ns/10ps
`default_nettype none
module oscfc_cal
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Control
    input wire logic i_start,
    input wire logic i_clear,
    // Status
    output logic o_busy,
    output logic o_done
);
    typedef enum logic [1:0]
    {
        CAL_IDLE = 2'b01,
        CAL_RUN = 2'b10
    } oscfc_cal_st_t;

    typedef struct packed
    {
        oscfc_cal_st_t st;
        logic [11:0] cnt;
        logic done;
    } oscfc_cal_t;

    oscfc_cal_t s_r;
    oscfc_cal_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        unique case (s_r.st)
            CAL_IDLE:
            begin
                if (i_start)
                begin
                    s_nxt.st = CAL_RUN;
                    s_nxt.cnt = 12'(oscfc_pkg::CAL_CYCLES - 1);
                end
            end
            CAL_RUN:
            begin
                if (s_r.cnt == 12'h000)
                begin
                    s_nxt.st = CAL_IDLE;
                    s_nxt.done = 1'b1;
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt - 12'h001;
                end
            end
            default:
            begin
                s_nxt.st = CAL_IDLE;
            end
        endcase
        // Restart on a start before the count reaches zero so the latest dividers are calibrated; one at count zero is lost
        if (i_start && s_r.st == CAL_RUN)
        begin
            s_nxt.cnt = 12'(oscfc_pkg::CAL_CYCLES - 1);
        end
        if (i_clear)
        begin
            s_nxt.st = CAL_IDLE;
            s_nxt.cnt = 12'h000;
            s_nxt.done = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            s_r <= '{st: CAL_IDLE, cnt: 12'h000, done: 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign o_busy = (s_r.st == CAL_RUN);
    assign o_done = s_r.done;
endmodule
`default_nettype wire

//--- verilog/oscfc_clkgate.sv
// Glitch-free gate for the output clock, one toggle per reference edge.
// Assumes the enable is a level from the register bank.
`timescale 1ns/10ps
`default_nettype none
module oscfc_clkgate
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Control
    input wire logic i_en,
    // Gated clock
    output logic o_clk
);
    typedef struct packed
    {
        logic clk;
    } oscfc_gate_t;

    oscfc_gate_t s_r;
    oscfc_gate_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        // Enable is only sampled while low, so no high phase is cut short
        if (s_r.clk)
        begin
            s_nxt.clk = 1'b0;
        end
        else
        begin
            s_nxt.clk = i_en;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            s_r <= '{clk: 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign o_clk = s_r.clk;
endmodule
`default_nettype wire

//--- verilog/oscfc_pkg.sv
// Constants of the oscillator frequency control register bank.
// Assumes a decoded byte access port and a single 200 MHz clock.
// Contract
// - Reset bit resets device, then self-clears
// - Calibration start launches calibration, self-clears
// - High-speed divider is 11 unsigned bits
// - Power2 codes 0..7 give 1,2,4,8,16,32,32,32
// - Feedback divider is 11.32 fixed point
// - Calibration bypass set skips calibration
// - Fine offset is 24-bit two's complement
// - Offset sign sets direction, zero is nominal
// - Offset applies only on top byte write
// - Page field selects 256-byte register page
// - Page bits become address bits 9 and 8
// - Fine offset changes apply synchronously
package oscfc_pkg;
    localparam logic [7:0] OFS_DEV_CTRL = 8'h07;
    localparam logic [7:0] OFS_OUT_GATE = 8'h11;
    localparam logic [7:0] OFS_HS_LOW = 8'h17;
    localparam logic [7:0] OFS_DIV_PACKED = 8'h18;
    localparam logic [7:0] OFS_FB_BYTE0 = 8'h1a;
    localparam logic [7:0] OFS_FB_BYTE1 = 8'h1b;
    localparam logic [7:0] OFS_FB_BYTE2 = 8'h1c;
    localparam logic [7:0] OFS_FB_BYTE3 = 8'h1d;
    localparam logic [7:0] OFS_FB_BYTE4 = 8'h1e;
    localparam logic [7:0] OFS_FB_BYTE5 = 8'h1f;
    localparam logic [7:0] OFS_CAL_BYPASS = 8'h45;
    localparam logic [7:0] OFS_FINE_BYTE0 = 8'he7;
    localparam logic [7:0] OFS_FINE_BYTE1 = 8'he8;
    localparam logic [7:0] OFS_FINE_BYTE2 = 8'he9;
    localparam logic [7:0] OFS_PAGE_SEL = 8'hff;
    localparam logic [1:0] PAGE_MAIN = 2'h0;

    localparam int BIT_RESET = 7;
    localparam int BIT_CAL_START = 3;
    localparam int BIT_OUT_GATE = 0;
    localparam int BIT_CAL_BYPASS = 7;
    localparam int POS_P2_DIV = 4;
    localparam int POS_HS_HIGH = 0;

    localparam logic out_gate_RST = 1'b1;
    localparam logic [7:0] RST_HS_LOW = 8'h54;
    localparam logic [2:0] RST_HS_HIGH = 3'h0;
    localparam logic [2:0] RST_P2_DIV = 3'h0;
    localparam logic [42:0] RST_FB_DIV = 43'h064_0000_0000;
    localparam logic RST_CAL_BYPASS = 1'b0;
    localparam logic [6:0] CAL_BYPASS_FILL = 7'h01;
    localparam logic [1:0] RST_PAGE = 2'h0;

    localparam int CLK_PERIOD_NS = 5;
    localparam int CAL_TIME_NS = 10000;
    localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

//--- verilog/oscfc_regs.sv
// Register bank of the programmable oscillator, behind a byte access port.
// Assumes the serial target has decoded each access into a one-cycle strobe.
`timescale 1ns/10ps
`default_nettype none
module oscfc_regs
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Register access
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rdata_vld,
    // Applied synthesis settings
    output logic [10:0] o_hs_div,
    output logic [5:0] o_p2_ratio,
    output logic [42:0] o_fb_div,
    output logic signed [23:0] o_fine_offset,
    output logic o_fine_upd,
    // Status and control
    output logic o_dev_reset,
    output logic o_cal_busy,
    output logic o_clk_out
);
    typedef struct packed
    {
        logic out_gate;
        logic [7:0] hs_low;
        logic [2:0] hs_high;
        logic [2:0] p2_div;
        logic [42:0] fb_div;
        logic cal_bypass;
        logic [15:0] fine_stage;
        logic [1:0] page;
        logic [10:0] act_hs;
        logic [5:0] act_p2;
        logic [42:0] act_fb;
        logic [23:0] act_fine;
        logic fine_upd;
        logic dev_rst;
        logic cal_go;
        logic [7:0] rdata;
        logic rvld;
    } oscfc_regs_t;

    localparam oscfc_regs_t RST_STATE = '{
        out_gate: oscfc_pkg::out_gate_RST,
        hs_low: oscfc_pkg::RST_HS_LOW,
        hs_high: oscfc_pkg::RST_HS_HIGH,
        p2_div: oscfc_pkg::RST_P2_DIV,
        fb_div: oscfc_pkg::RST_FB_DIV,
        cal_bypass: oscfc_pkg::RST_CAL_BYPASS,
        fine_stage: 16'h0000,
        page: oscfc_pkg::RST_PAGE,
        act_hs: {oscfc_pkg::RST_HS_HIGH, oscfc_pkg::RST_HS_LOW},
        act_p2: 6'h01,
        act_fb: oscfc_pkg::RST_FB_DIV,
        act_fine: 24'h000000,
        fine_upd: 1'b0,
        dev_rst: 1'b0,
        cal_go: 1'b0,
        rdata: 8'h00,
        rvld: 1'b0
    };

    oscfc_regs_t s_r;
    oscfc_regs_t s_nxt;
    logic cal_busy;
    logic [9:0] full_addr;
    logic page_main;

    function automatic logic [5:0] p2_ratio(input logic [2:0] code);
        logic [5:0] r;
        r = 6'h20;
        if (code < 3'h5)
        begin
            r = 6'h01 << code;
        end
        return r;
    endfunction

    // Page forms the top address bits
    assign full_addr = {s_r.page, i_addr};
    assign page_main = (full_addr[9:8] == oscfc_pkg::PAGE_MAIN);

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.fine_upd = 1'b0;
        s_nxt.dev_rst = 1'b0;
        s_nxt.cal_go = 1'b0;
        s_nxt.rvld = 1'b0;
        if (i_wr_stb)
        begin
            // Selector stays reachable from every page so the host can return
            if (i_addr == oscfc_pkg::OFS_PAGE_SEL)
            begin
                s_nxt.page = i_wdata[1:0];
            end
            else if (page_main)
            begin
                unique case (i_addr)
                    oscfc_pkg::OFS_DEV_CTRL:
                    begin
                        if (i_wdata[oscfc_pkg::BIT_RESET])
                        begin
                            s_nxt = RST_STATE;
                            s_nxt.dev_rst = 1'b1;
                        end
                        else if (i_wdata[oscfc_pkg::BIT_CAL_START])
                        begin
                            // Staged dividers reach the synthesiser only here
                            s_nxt.cal_go = !s_r.cal_bypass;
                            s_nxt.act_hs = {s_r.hs_high, s_r.hs_low};
                            s_nxt.act_p2 = p2_ratio(s_r.p2_div);
                            s_nxt.act_fb = s_r.fb_div;
                        end
                    end
                    oscfc_pkg::OFS_OUT_GATE: s_nxt.out_gate = i_wdata[oscfc_pkg::BIT_OUT_GATE];
                    oscfc_pkg::OFS_HS_LOW: s_nxt.hs_low = i_wdata;
                    oscfc_pkg::OFS_DIV_PACKED:
                    begin
                        s_nxt.p2_div = i_wdata[oscfc_pkg::POS_P2_DIV +: 3];
                        s_nxt.hs_high = i_wdata[oscfc_pkg::POS_HS_HIGH +: 3];
                    end
                    oscfc_pkg::OFS_FB_BYTE0: s_nxt.fb_div[7:0] = i_wdata;
                    oscfc_pkg::OFS_FB_BYTE1: s_nxt.fb_div[15:8] = i_wdata;
                    oscfc_pkg::OFS_FB_BYTE2: s_nxt.fb_div[23:16] = i_wdata;
                    oscfc_pkg::OFS_FB_BYTE3: s_nxt.fb_div[31:24] = i_wdata;
                    oscfc_pkg::OFS_FB_BYTE4: s_nxt.fb_div[39:32] = i_wdata;
                    oscfc_pkg::OFS_FB_BYTE5: s_nxt.fb_div[42:40] = i_wdata[2:0];
                    oscfc_pkg::OFS_CAL_BYPASS:
                    begin
                        s_nxt.cal_bypass = i_wdata[oscfc_pkg::BIT_CAL_BYPASS];
                    end
                    oscfc_pkg::OFS_FINE_BYTE0: s_nxt.fine_stage[7:0] = i_wdata;
                    oscfc_pkg::OFS_FINE_BYTE1: s_nxt.fine_stage[15:8] = i_wdata;
                    oscfc_pkg::OFS_FINE_BYTE2:
                    begin
                        // Whole word moves in one edge, never a half-updated value
                        s_nxt.act_fine = {i_wdata, s_r.fine_stage};
                        s_nxt.fine_upd = 1'b1;
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
        if (i_rd_stb)
        begin
            s_nxt.rvld = 1'b1;
            s_nxt.rdata = 8'h00;
            if (i_addr == oscfc_pkg::OFS_PAGE_SEL)
            begin
                s_nxt.rdata = {6'h00, s_r.page};
            end
            else if (page_main)
            begin
                unique case (i_addr)
                    // Reset bit always reads zero; start reads one while calibrating
                    oscfc_pkg::OFS_DEV_CTRL: s_nxt.rdata = {4'h0, cal_busy, 3'h0};
                    oscfc_pkg::OFS_OUT_GATE: s_nxt.rdata = {7'h00, s_r.out_gate};
                    oscfc_pkg::OFS_HS_LOW: s_nxt.rdata = s_r.hs_low;
                    oscfc_pkg::OFS_DIV_PACKED: s_nxt.rdata = {1'b0, s_r.p2_div, 1'b0, s_r.hs_high};
                    oscfc_pkg::OFS_FB_BYTE0: s_nxt.rdata = s_r.fb_div[7:0];
                    oscfc_pkg::OFS_FB_BYTE1: s_nxt.rdata = s_r.fb_div[15:8];
                    oscfc_pkg::OFS_FB_BYTE2: s_nxt.rdata = s_r.fb_div[23:16];
                    oscfc_pkg::OFS_FB_BYTE3: s_nxt.rdata = s_r.fb_div[31:24];
                    oscfc_pkg::OFS_FB_BYTE4: s_nxt.rdata = s_r.fb_div[39:32];
                    oscfc_pkg::OFS_FB_BYTE5: s_nxt.rdata = {5'h00, s_r.fb_div[42:40]};
                    oscfc_pkg::OFS_CAL_BYPASS:
                    begin
                        s_nxt.rdata = {s_r.cal_bypass, oscfc_pkg::CAL_BYPASS_FILL};
                    end
                    oscfc_pkg::OFS_FINE_BYTE0: s_nxt.rdata = s_r.fine_stage[7:0];
                    oscfc_pkg::OFS_FINE_BYTE1: s_nxt.rdata = s_r.fine_stage[15:8];
                    oscfc_pkg::OFS_FINE_BYTE2: s_nxt.rdata = s_r.act_fine[23:16];
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            s_r <= RST_STATE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    oscfc_cal u_cal
    (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_start(s_r.cal_go),
        .i_clear(s_r.dev_rst),
        .o_busy(cal_busy),
        .o_done()
    );

    // Output held low while calibrating, except a high phase begun at the edge where busy rises
    oscfc_clkgate u_gate
    (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_en(s_r.out_gate && !cal_busy),
        .o_clk(o_clk_out)
    );

    assign o_rdata = s_r.rdata;
    assign o_rdata_vld = s_r.rvld;
    assign o_hs_div = s_r.act_hs;
    assign o_p2_ratio = s_r.act_p2;
    assign o_fb_div = s_r.act_fb;
    assign o_fine_offset = s_r.act_fine;
    assign o_fine_upd = s_r.fine_upd;
    assign o_dev_reset = s_r.dev_rst;
    assign o_cal_busy = cal_busy;
endmodule
`default_nettype wire
